/* rtl/apcl_core.sv */
// Positioning and command logic of the actuator: registers, motion control, wake check.
// Assumes a framer that issues one-cycle register strobes and an on-clock position source.
`timescale 1ns/100ps
module apcl_core (
	input  wire logic        clk,
	input  wire logic        rst,
	input  wire logic        regWr,
	input  wire logic        regRd,
	input  wire logic [15:0] regAddr,
	input  wire logic [15:0] regWrData,
	output logic             regAck,
	output logic      [7:0]  regExc,
	output logic      [15:0] regRdData,
	input  wire logic [15:0] posActual,
	input  wire logic [11:0] motorCurrent,
	input  wire logic [11:0] currentLimitIn,
	input  wire logic [11:0] currentLimitOut,
	input  wire logic [1:0]  hallPins,
	input  wire logic        localPanelPin,
	input  wire logic [1:0]  retainedHall,
	input  wire logic        retainedValid,
	input  wire logic        calibDone,
	output logic             motorOn,
	output logic             motorOutward,
	output logic             motorSlow,
	output logic      [1:0]  hallStore,
	output logic             posValidOut
);
	typedef struct packed {
		logic [15:0]        goal;
		logic [15:0]        cmd;
		logic [3:0][15:0]   preset;
		logic [15:0]        slowdown;
		logic [15:0]        target;
		apcl_pkg::apcl_motion_t motion;
		logic               dirOut;
		logic               slow;
		logic [15:0]        cause;
		logic               posValid;
		logic [1:0]         wakeCnt;
		logic [1:0]         hallLast;
		logic               ack;
		logic [7:0]         exc;
		logic [15:0]        rdData;
	} apcl_state_t;

	apcl_state_t s;
	apcl_state_t next_s;
	logic [1:0]  hallSync;
	logic        localSync;

	// Pins cross into the clock domain before any decision reads them.
	apcl_sync #(.WIDTH(3)) pinSync (
		.clk  (clk),
		.rst  (rst),
		.din  ({hallPins, localPanelPin}),
		.dout ({hallSync, localSync})
	);

	logic [15:0] distance;
	logic        reached;
	logic        overCurrent;
	logic        wrGoal;
	logic        wrCmd;
	logic        wrSlow;
	logic        wrPreset;
	logic        isPresetCmd;
	logic [1:0]  presetIdx;
	logic [1:0]  cmdIdx;
	logic [15:0] statusWord;
	logic        badValue;
	logic        startNow;
	logic        nextDir;
	logic [15:0] nextTarget;

	// Decode of the incoming strobe and of the motion geometry.
	always_comb begin
		distance    = (posActual > s.target) ? (posActual - s.target) : (s.target - posActual);
		reached     = s.dirOut ? (posActual >= s.target) : (posActual <= s.target);
		overCurrent = s.dirOut ? (motorCurrent > currentLimitOut)
		                       : (motorCurrent > currentLimitIn);
		wrGoal      = regWr && (regAddr == apcl_pkg::ADDR_GOAL);
		wrCmd       = regWr && (regAddr == apcl_pkg::ADDR_CMD);
		wrSlow      = regWr && (regAddr == apcl_pkg::ADDR_SLOWDOWN);
		wrPreset    = regWr && (regAddr >= apcl_pkg::ADDR_PRESET1)
		                    && (regAddr <= apcl_pkg::ADDR_PRESET4);
		presetIdx   = 2'(regAddr - apcl_pkg::ADDR_PRESET1);
		cmdIdx      = 2'(regWrData - apcl_pkg::CMD_PRESET1);
		isPresetCmd = (regWrData >= apcl_pkg::CMD_PRESET1) && (regWrData <= apcl_pkg::CMD_PRESET4);
		// Positions beyond the stroke and oversize distances are refused.
		badValue    = ((wrGoal || wrPreset) && (regWrData > apcl_pkg::POS_MAX))
		           || (wrSlow && (regWrData > apcl_pkg::SLOWDOWN_MAX))
		           || (wrCmd && (regWrData > apcl_pkg::CMD_MAX));
		statusWord  = '0;
		statusWord[apcl_pkg::BIT_READY] = (s.motion == apcl_pkg::APCL_IDLE) && !overCurrent;
		statusWord[apcl_pkg::BIT_LOCAL] = localSync;
		statusWord[apcl_pkg::BIT_VALID] = s.posValid;
	end

	// Target and direction of a move started by this cycle's command write.
	always_comb begin
		nextTarget = s.goal;
		if (isPresetCmd) begin
			nextTarget = s.preset[cmdIdx];
		end
		nextDir  = nextTarget > posActual;
		startNow = wrCmd && !badValue
		        && ((regWrData == apcl_pkg::CMD_RUN_GOAL) || isPresetCmd);
	end

	// Next-state logic for registers, motion and wake check.
	always_comb begin
		next_s        = s;
		next_s.ack    = regWr || regRd;
		next_s.exc    = apcl_pkg::EXC_OK;
		next_s.rdData = '0;
		// Register writes; a refused value leaves the register untouched.
		if (regWr) begin
			if (!(wrGoal || wrCmd || wrSlow || wrPreset)) begin
				next_s.exc = apcl_pkg::EXC_ADDRESS;
			end else if (badValue) begin
				next_s.exc = apcl_pkg::EXC_VALUE;
			end else begin
				if (wrGoal) begin
					next_s.goal = regWrData;
				end
				if (wrCmd) begin
					next_s.cmd = regWrData;
				end
				if (wrSlow) begin
					next_s.slowdown = regWrData;
				end
				if (wrPreset) begin
					next_s.preset[presetIdx] = regWrData;
				end
			end
		end else if (regRd) begin
			case (regAddr)
				apcl_pkg::ADDR_GOAL:     next_s.rdData = s.goal;
				apcl_pkg::ADDR_CMD:      next_s.rdData = s.cmd;
				apcl_pkg::ADDR_MOTION:   next_s.rdData = {14'h0000, s.motion};
				apcl_pkg::ADDR_STATUS:   next_s.rdData = statusWord;
				apcl_pkg::ADDR_CAUSE:    next_s.rdData = s.cause;
				apcl_pkg::ADDR_SLOWDOWN: next_s.rdData = s.slowdown;
				default: begin
					if ((regAddr >= apcl_pkg::ADDR_PRESET1) && (regAddr <= apcl_pkg::ADDR_PRESET4)) begin
						next_s.rdData = s.preset[presetIdx];
					end else begin
						next_s.exc = apcl_pkg::EXC_ADDRESS;
					end
				end
			endcase
		end
		// Motion control. A new run command re-targets a move in progress.
		case (s.motion)
			apcl_pkg::APCL_IDLE: begin
				next_s.slow = 1'b0;
			end
			apcl_pkg::APCL_RUN: begin
				next_s.slow = distance <= s.slowdown;
				if (overCurrent) begin
					next_s.motion = apcl_pkg::APCL_IDLE;
					next_s.cause  = apcl_pkg::CAUSE_CURRENT;
					next_s.slow   = 1'b0;
				end else if (reached) begin
					next_s.motion = apcl_pkg::APCL_IDLE;
					next_s.cause  = apcl_pkg::CAUSE_REACHED;
					next_s.slow   = 1'b0;
				end
			end
			default: begin
				next_s.motion = apcl_pkg::APCL_IDLE;
			end
		endcase
		if (startNow) begin
			next_s.target = nextTarget;
			next_s.dirOut = nextDir;
			if ((nextDir && (motorCurrent > currentLimitOut))
			    || (!nextDir && (motorCurrent > currentLimitIn))) begin
				next_s.motion = apcl_pkg::APCL_IDLE;
				next_s.cause  = apcl_pkg::CAUSE_CURRENT;
			end else begin
				next_s.motion = apcl_pkg::APCL_RUN;
			end
		end
		// Wake check: hall state must match the state retained over power loss.
		if (s.wakeCnt != apcl_pkg::WAKE_CYCLES) begin
			next_s.wakeCnt = s.wakeCnt + 2'h1;
			if (next_s.wakeCnt == apcl_pkg::WAKE_CYCLES) begin
				next_s.posValid = retainedValid && (hallSync == retainedHall);
			end
		end else if (calibDone) begin
			next_s.posValid = 1'b1;
		end
		next_s.hallLast = hallSync;
	end

	// All state is one register; reset leaves the actuator idle and untrusted.
	always_ff @(posedge clk) begin
		if (rst) begin
			s          <= '0;
			s.slowdown <= apcl_pkg::SLOWDOWN_RESET;
			s.cause    <= apcl_pkg::CAUSE_NONE;
		end else begin
			s <= next_s;
		end
	end

	assign regAck       = s.ack;
	assign regExc       = s.exc;
	assign regRdData    = s.rdData;
	assign motorOn      = s.motion == apcl_pkg::APCL_RUN;
	assign motorOutward = s.dirOut;
	assign motorSlow    = s.slow;
	assign hallStore    = s.hallLast;
	assign posValidOut  = s.posValid;

	default clocking cb @(posedge clk); endclocking
	default disable iff (rst);

	// Checks on the register port, the motion control and the wake check, all on clk.
	bad_goal_rejected_a: assert property (
		wrGoal && (regWrData > apcl_pkg::POS_MAX)
		|=> regAck && (regExc == apcl_pkg::EXC_VALUE) && $stable(s.goal)
	) else $error("Out-of-range goal accepted.");
	overcurrent_stop_a: assert property (
		motorOn && overCurrent && !startNow
		|=> !motorOn && (s.cause == apcl_pkg::CAUSE_CURRENT)
	) else $error("Motor kept running over current.");
	goal_run_start_a: assert property (
		startNow && (regWrData == apcl_pkg::CMD_RUN_GOAL)
		|=> s.target == $past(s.goal)
	) else $error("Run command did not aim at goal.");
	preset_run_start_a: assert property (
		startNow && isPresetCmd
		|=> s.target == $past(s.preset[cmdIdx])
	) else $error("Preset command aimed wrongly.");
	goal_reached_idle_a: assert property (
		motorOn && reached && !overCurrent && !startNow
		|=> (s.motion == apcl_pkg::APCL_IDLE) && (s.cause == apcl_pkg::CAUSE_REACHED)
	) else $error("Reaching goal did not end move.");
	slow_zone_a: assert property (
		motorOn && !overCurrent && !reached && (distance <= s.slowdown)
		|=> motorSlow
	) else $error("No slow-down inside distance.");
	slowdown_write_a: assert property (
		wrSlow && !badValue ##1 !wrSlow
		|-> s.slowdown == $past(regWrData)
	) else $error("Slow-down write lost.");
	preset_write_a: assert property (
		wrPreset && !badValue
		|=> s.preset[$past(presetIdx)] == $past(regWrData)
	) else $error("Preset write lost.");
	wake_hall_check_a: assert property (
		(s.wakeCnt == 2'h2) && (hallSync != retainedHall)
		|=> !s.posValid
	) else $error("Hall change kept position valid.");
	undefined_cmd_a: assert property (
		wrCmd && !startNow && !motorOn
		|=> !motorOn
	) else $error("Undefined command started motion.");

	// Main scenarios; long moves need the wide windows before the slow zone is met.
	goal_move_c: cover property (startNow ##[1:1000] (motorOn && motorSlow) ##[1:1000] !motorOn);
	preset_move_c: cover property (startNow && isPresetCmd ##1 motorOn);
	value_reject_c: cover property (regAck && (regExc == apcl_pkg::EXC_VALUE));
endmodule // apcl_core

/* rtl/apcl_pkg.sv */
// Constants and types shared by the actuator positioning and command logic.
// Assumes one 40 MHz clock and a register port fed by the field-bus framer.
package apcl_pkg;
	// Register offsets.
	localparam logic [15:0] ADDR_GOAL     = 16'h0001;
	localparam logic [15:0] ADDR_CMD      = 16'h0002;
	localparam logic [15:0] ADDR_MOTION   = 16'h0003;
	localparam logic [15:0] ADDR_STATUS   = 16'h0004;
	localparam logic [15:0] ADDR_CAUSE    = 16'h0005;
	localparam logic [15:0] ADDR_PRESET1  = 16'h0006;
	localparam logic [15:0] ADDR_PRESET4  = 16'h0009;
	localparam logic [15:0] ADDR_SLOWDOWN = 16'h0011;
	// Status word bit positions.
	localparam int BIT_READY = 4;
	localparam int BIT_LOCAL = 9;
	localparam int BIT_VALID = 10;
	// Reset values and limits.
	localparam logic [15:0] SLOWDOWN_RESET = 16'h0014;
	localparam logic [15:0] POS_MAX        = 16'h0FA0;
	localparam logic [15:0] SLOWDOWN_MAX   = 16'h03E8;
	localparam logic [15:0] CMD_MAX        = 16'h00FF;
	// Command codes.
	localparam logic [15:0] CMD_RUN_GOAL  = 16'h0001;
	localparam logic [15:0] CMD_PRESET1   = 16'h0006;
	localparam logic [15:0] CMD_PRESET4   = 16'h0009;
	// Stop causes.
	localparam logic [15:0] CAUSE_REACHED = 16'h0000;
	localparam logic [15:0] CAUSE_CURRENT = 16'h0001;
	localparam logic [15:0] CAUSE_NONE    = 16'h00FF;
	// Exception codes.
	localparam logic [7:0] EXC_OK      = 8'h00;
	localparam logic [7:0] EXC_ADDRESS = 8'h02;
	localparam logic [7:0] EXC_VALUE   = 8'h03;
	// Cycles after reset before synchronised hall state is trusted.
	localparam logic [1:0] WAKE_CYCLES = 2'h3;

	typedef enum logic [1:0] {
		APCL_IDLE = 2'b00,
		APCL_RUN  = 2'b01
	} apcl_motion_t;
endpackage

/* rtl/apcl_sync.sv */
// Two-flop synchroniser for a group of pin inputs.
// Assumes the inputs are asynchronous to clk and change slowly.
`timescale 1ns/100ps
module apcl_sync #(
	parameter int WIDTH = 1
) (
	input  wire logic             clk,
	input  wire logic             rst,
	input  wire logic [WIDTH-1:0] din,
	output logic      [WIDTH-1:0] dout
);
	typedef struct packed {
		logic [WIDTH-1:0] stage1;
		logic [WIDTH-1:0] stage2;
	} apcl_sync_t;

	apcl_sync_t s;
	apcl_sync_t next_s;

	// The first stage feeds only the second stage.
	always_comb begin
		next_s.stage1 = din;
		next_s.stage2 = s.stage1;
	end

	// Registered stages, cleared by reset.
	always_ff @(posedge clk) begin
		if (rst) begin
			s <= '0;
		end else begin
			s <= next_s;
		end
	end

	assign dout = s.stage2;
endmodule // apcl_sync

/* dv/apcl_plc_model.sv */
// Controller model for the register port: single-word reads and writes.
// Assumes a one-cycle strobe that is answered by regAck on the following cycle.
`timescale 1ns/100ps
module apcl_plc_model #(
	parameter int NODE_ADDR = 17 // Bus address, unique and within 1 to 246.
) (
	input  wire logic        clk,
	output logic             regWr,
	output logic             regRd,
	output logic      [15:0] regAddr,
	output logic      [15:0] regWrData,
	input  wire logic        regAck,
	input  wire logic [7:0]  regExc,
	input  wire logic [15:0] regRdData
);
	logic [7:0]  exc;
	logic [15:0] rdv;
	logic        ackSeen;

	// The port idles with no strobe raised.
	initial begin
		regWr = 1'b0;
		regRd = 1'b0;
		regAddr = 16'h0000;
		regWrData = 16'h0000;
	end

	// One request, answer picked up while regAck stands; idle lines are scrambled.
	task automatic xfer(input logic w, input logic [15:0] a, input logic [15:0] d);
		@(negedge clk);
		regWr = w;
		regRd = !w;
		regAddr = a;
		regWrData = d;
		@(negedge clk);
		ackSeen = regAck;
		exc = regExc;
		rdv = regRdData;
		regWr = 1'b0;
		regRd = 1'b0;
		regAddr = ~a;
		regWrData = ~d;
	endtask

	// Reads whether the status word allows motion: ready, no local panel, position valid.
	task automatic ready_to_run(output logic ok);
		xfer(1'b0, apcl_pkg::ADDR_STATUS, 16'h0000);
		ok = (rdv[4] === 1'b1) && (rdv[9] === 1'b0) && (rdv[10] === 1'b1);
	endtask
endmodule // apcl_plc_model

/* dv/tb.sv */
// Self-checking bench for the actuator positioning and command logic.
// Assumes the controller model drives the register port and a simple plant moves posActual.
`timescale 1ns/100ps
module tb;
	logic        clk, rst, regWr, regRd, regAck, calibDone, motorOn, motorOutward, motorSlow;
	logic        posValidOut, localPanelPin, retainedValid, ok;
	logic [15:0] regAddr, regWrData, regRdData, posActual, g;
	logic [7:0]  regExc;
	logic [11:0] motorCurrent, currentLimitIn, currentLimitOut;
	logic [1:0]  hallPins, retainedHall, hallStore;
	int          miscompares, checks, slowCnt, n, sd, seed;
	logic [15:0] la[3] = '{apcl_pkg::ADDR_GOAL, apcl_pkg::ADDR_SLOWDOWN, apcl_pkg::ADDR_CMD};
	logic [15:0] lv[3] = '{16'h0FA1, 16'h03E9, 16'h0100};
	logic [15:0] le[3] = '{16'h0000, 16'h0014, 16'h0000};

	apcl_core u_dut (.clk(clk), .rst(rst), .regWr(regWr), .regRd(regRd), .regAddr(regAddr),
		.regWrData(regWrData), .regAck(regAck), .regExc(regExc), .regRdData(regRdData),
		.posActual(posActual), .motorCurrent(motorCurrent), .currentLimitIn(currentLimitIn),
		.currentLimitOut(currentLimitOut), .hallPins(hallPins), .localPanelPin(localPanelPin),
		.retainedHall(retainedHall), .retainedValid(retainedValid), .calibDone(calibDone),
		.motorOn(motorOn), .motorOutward(motorOutward), .motorSlow(motorSlow),
		.hallStore(hallStore), .posValidOut(posValidOut));
	apcl_plc_model p (.clk(clk), .regWr(regWr), .regRd(regRd), .regAddr(regAddr),
		.regWrData(regWrData), .regAck(regAck), .regExc(regExc), .regRdData(regRdData));

	// Free-running 40 MHz clock.
	initial begin
		clk = 1'b0;
		forever #12.5 clk = ~clk;
	end

	// Plant: one tenth of a millimetre per cycle while the motor runs.
	always @(negedge clk) begin
		if (motorOn === 1'b1) posActual <= motorOutward ? posActual + 16'h0001 : posActual - 16'h0001;
		if (motorSlow === 1'b1) slowCnt <= slowCnt + 1;
	end

	task automatic cmp(input logic [15:0] got, input logic [15:0] exp, input string m);
		checks++;
		if (got !== exp) begin
			miscompares++;
			$display("[FAIL] %0t %s got %h exp %h", $time, m, got, exp);
		end
	endtask

	// Slow cycles expected: the shorter of the start distance and the slow-down span.
	function automatic int exp_slow(input int d0, input int s);
		return (d0 < s) ? d0 : s;
	endfunction

	task automatic do_reset();
		rst = 1'b1;
		repeat (10) @(negedge clk);
		rst = 1'b0;
		repeat (4) @(negedge clk);
	endtask

	// Commands a run and waits, bounded, for the stop.
	task automatic run_to(input logic [15:0] cmd, input logic [15:0] t);
		int          d0;
		logic [15:0] p0;
		p0 = posActual;
		d0 = (t > posActual) ? int'(t - posActual) : int'(posActual - t);
		p.ready_to_run(ok);
		cmp({15'h0000, ok}, 16'h0001, "not ready");
		p.xfer(1'b1, apcl_pkg::ADDR_CMD, cmd);
		cmp({7'h00, p.ackSeen, p.exc}, 16'h0100, "command ack");
		cmp({15'h0000, motorOutward}, {15'h0000, t > p0}, "direction");
		slowCnt = 0;
		n = 0;
		while (motorOn === 1'b1 && n < 5000) begin
			@(negedge clk);
			n++;
		end
		cmp({15'h0000, motorOn}, 16'h0000, "run timeout");
		g = (posActual > t) ? posActual - t : t - posActual;
		cmp({15'h0000, g <= 16'h0002}, 16'h0001, "stop position");
		cmp({15'h0000, slowCnt >= exp_slow(d0, sd) - 1 && slowCnt <= exp_slow(d0, sd) + 2},
			16'h0001, "slow span");
		p.xfer(1'b0, apcl_pkg::ADDR_MOTION, 16'h0000);
		cmp(p.rdv, 16'h0000, "motion state");
		p.xfer(1'b0, apcl_pkg::ADDR_CAUSE, 16'h0000);
		cmp(p.rdv, apcl_pkg::CAUSE_REACHED, "stop cause");
	endtask

	// Main sequence.
	initial begin
		seed = $urandom(32'h287b_a2dc);
		{rst, calibDone, localPanelPin, retainedValid} = 4'b1001;
		{hallPins, retainedHall} = 4'b0101;
		{motorCurrent, currentLimitIn, currentLimitOut} = {12'h010, 12'h800, 12'h800};
		posActual = 16'h012C;
		do_reset();
		p.xfer(1'b0, apcl_pkg::ADDR_SLOWDOWN, 16'h0000);
		cmp(p.rdv, apcl_pkg::SLOWDOWN_RESET, "slowdown reset");
		cmp({15'h0000, p.NODE_ADDR >= 1 && p.NODE_ADDR <= 246}, 16'h0001, "node address");
		p.xfer(1'b0, apcl_pkg::ADDR_STATUS, 16'h0000);
		cmp({15'h0000, p.rdv[10]}, 16'h0001, "valid after wake");
		p.xfer(1'b0, 16'h000A, 16'h0000);
		cmp({8'h00, p.exc}, 16'h0002, "unmapped");
		$display("test reset and map done");
		for (int i = 0; i < 3; i++) begin
			p.xfer(1'b1, la[i], lv[i]);
			cmp({8'h00, p.exc}, 16'h0003, "limit");
			p.xfer(1'b0, la[i], 16'h0000);
			cmp(p.rdv, le[i], "kept");
		end
		$display("test limits done");
		for (int i = 0; i < 6; i++) begin
			sd = $urandom_range(5, 60);
			g = 16'($urandom_range(50, 900));
			p.xfer(1'b1, apcl_pkg::ADDR_SLOWDOWN, 16'(sd));
			if (i < 2) begin
				p.xfer(1'b1, apcl_pkg::ADDR_GOAL, g);
				run_to(apcl_pkg::CMD_RUN_GOAL, g);
			end else begin
				p.xfer(1'b1, apcl_pkg::ADDR_PRESET1 + 16'(i - 2), g);
				p.xfer(1'b0, apcl_pkg::ADDR_PRESET1 + 16'(i - 2), 16'h0000);
				cmp(p.rdv, g, "preset");
				run_to(apcl_pkg::CMD_PRESET1 + 16'(i - 2), g);
			end
		end
		$display("test runs done");
		p.xfer(1'b1, apcl_pkg::ADDR_CMD, 16'h0002);
		repeat (5) @(negedge clk);
		cmp({15'h0000, motorOn}, 16'h0000, "undefined code");
		motorCurrent = 12'($urandom_range(12'h801, 12'hFFF));
		p.xfer(1'b1, apcl_pkg::ADDR_GOAL, posActual + 16'h0064);
		p.xfer(1'b1, apcl_pkg::ADDR_CMD, apcl_pkg::CMD_RUN_GOAL);
		cmp({15'h0000, motorOn}, 16'h0000, "overcurrent");
		p.xfer(1'b0, apcl_pkg::ADDR_CAUSE, 16'h0000);
		cmp(p.rdv, apcl_pkg::CAUSE_CURRENT, "cause current");
		motorCurrent = 12'h010;
		$display("test refusals done");
		hallPins = 2'b10;
		do_reset();
		cmp({15'h0000, posValidOut}, 16'h0000, "hall moved");
		cmp({14'h0000, hallStore}, 16'h0002, "hall store");
		localPanelPin = 1'b1;
		repeat (4) @(negedge clk);
		p.ready_to_run(ok);
		cmp({15'h0000, p.rdv[9]}, 16'h0001, "local panel");
		localPanelPin = 1'b0;
		calibDone = 1'b1;
		@(negedge clk);
		calibDone = 1'b0;
		@(negedge clk);
		cmp({15'h0000, posValidOut}, 16'h0001, "calibrated");
		$display("test wake done");
		final_report();
	end

	// Cuts a hang short.
	initial begin
		repeat (80000) @(posedge clk);
		miscompares++;
		final_report();
	end

	task automatic final_report();
		$display("checks %0d miscompares %0d", checks, miscompares);
		if (miscompares == 0 && checks > 0) begin
			$display("verification passed");
		end else begin
			$display("verification failed");
		end
		$finish;
	endtask
endmodule // tb
